// file: core/lee_delay_timer.sv
// Debounce timer that holds off a level change for a programmed count.
`timescale 1ns/1ps
module lee_delay_timer
    import lee_pkg::*;
#(
    parameter int WIDTH = LEE_DELAY_WIDTH
) (
    input wire logic i_clock, // System clock.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic i_ce, // Clock enable.
    input wire logic i_level, // Raw equation result.
    input wire logic [WIDTH-1:0] i_on_delay, // Cycles before activation.
    input wire logic [WIDTH-1:0] i_off_delay, // Cycles before release.
    output logic o_level // Delayed output level.
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] limit;

    assign limit = o_level ? i_off_delay : i_on_delay;

    // Counter restarts whenever the raw level agrees with the output again.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_reg <= '0;
        end else if (i_ce) begin
            if (i_level == o_level || count_reg >= limit) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_level <= 1'b0;
        end else if (i_ce && i_level != o_level && count_reg >= limit) begin
            o_level <= i_level;
        end
    end

    property p_hold_stable;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_level == o_level) |=> (count_reg == '0);
    endproperty
    a_hold_stable: assert property (p_hold_stable) else $error("timer not restarted");

    property p_no_early_change;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && count_reg < limit) |=> (o_level == $past(o_level));
    endproperty
    a_no_early_change: assert property (p_no_early_change) else $error("early output");
endmodule : lee_delay_timer

// file: core/lee_evaluator.sv
// Logic equation evaluator with remote control word and delayed output.
// Notes on behaviour
// - Remote control word is one 16-bit unsigned value of independent bits.
// - Word bit n drives remote control bit n+1, command variables 04.44 to 04.59.
// - Sign value passes the command variable unchanged.
// - Sign NOT passes the complement of the command variable.
// - Sign constant 0 forces the path false.
// - Sign constant 1 forces the path true.
// - Operators AND, NAND, OR, NOR, XOR, NXOR with standard truth tables.
// - Input one op-one input two, then result op-two input three.
// - Output action is switched on only when the result is true; it stays on through the off delay.
// - Separate programmable on and off delays shape the output.
`timescale 1ns/1ps
module lee_evaluator
    import lee_pkg::*;
#(
    parameter int DELAY_WIDTH = LEE_DELAY_WIDTH
) (
    input wire logic i_clock, // System clock, 50 MHz.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic i_ce, // Clock enable; low freezes all state.
    input wire logic i_obj_write, // Object write strobe from the fieldbus stack.
    input wire logic [15:0] i_obj_index, // Object index of the write.
    input wire logic [LEE_CTRL_WIDTH-1:0] i_obj_data, // Written control word.
    input wire logic [LEE_SEL_WIDTH-1:0] i_command_input_sel_1, // Source of input 1.
    input wire logic [LEE_SEL_WIDTH-1:0] i_command_input_sel_2, // Source of input 2.
    input wire logic [LEE_SEL_WIDTH-1:0] i_command_input_sel_3, // Source of input 3.
    input wire logic [1:0] i_input_sign_select_1, // Sign of input 1.
    input wire logic [1:0] i_input_sign_select_2, // Sign of input 2.
    input wire logic [1:0] i_input_sign_select_3, // Sign of input 3.
    input wire logic [2:0] i_combine_operator_select_1, // First operator.
    input wire logic [2:0] i_combine_operator_select_2, // Second operator.
    input wire logic [DELAY_WIDTH-1:0] i_on_delay, // Activation delay in cycles.
    input wire logic [DELAY_WIDTH-1:0] i_off_delay, // Release delay in cycles.
    output logic [LEE_CTRL_WIDTH-1:0] o_remote_bits, // Remote bits 1 to 16.
    output logic o_equation_result, // Undelayed result, registered.
    output logic o_action // Delayed output action.
);
    logic [LEE_CTRL_WIDTH-1:0] remote_control_word_three_reg;
    logic [LEE_INPUTS-1:0] cmd;
    logic [LEE_INPUTS-1:0] signed_in;
    logic stage_one;
    logic result_next;
    logic result_reg;
    logic value_chain;

    // The word is taken whole; each bit is an independent command variable.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            remote_control_word_three_reg <= LEE_CTRL_RESET;
        end else if (i_ce && i_obj_write && i_obj_index == LEE_CTRL_WORD_INDEX) begin
            remote_control_word_three_reg <= i_obj_data;
        end
    end

    assign o_remote_bits = remote_control_word_three_reg;

    function automatic logic pick(input logic [LEE_SEL_WIDTH-1:0] sel,
                                  input logic [LEE_CTRL_WIDTH-1:0] word,
                                  input logic own);
        logic v;
        v = 1'b0;
        if (sel <= LEE_SEL_REMOTE_MAX) begin
            v = word[sel[3:0]];
        end else if (sel == LEE_SEL_OWN_OUTPUT) begin
            v = own;
        end
        return v;
    endfunction : pick

    function automatic logic apply_sign(input logic [1:0] s, input logic c);
        logic v;
        v = c;
        unique case (lee_sign_e'(s))
            LEE_SIGN_VALUE: v = c;
            LEE_SIGN_NOT: v = ~c;
            LEE_SIGN_ZERO: v = 1'b0;
            LEE_SIGN_ONE: v = 1'b1;
        endcase
        return v;
    endfunction : apply_sign

    function automatic logic combine(input logic [2:0] op, input logic a, input logic b);
        logic v;
        v = 1'b0;
        case (lee_op_e'(op))
            LEE_OP_AND: v = a & b;
            LEE_OP_NAND: v = ~(a & b);
            LEE_OP_OR: v = a | b;
            LEE_OP_NOR: v = ~(a | b);
            LEE_OP_XOR: v = a ^ b;
            LEE_OP_NXOR: v = ~(a ^ b);
            default: v = 1'b0;
        endcase
        return v;
    endfunction : combine

    always_comb begin
        cmd[0] = pick(i_command_input_sel_1, remote_control_word_three_reg, o_action);
        cmd[1] = pick(i_command_input_sel_2, remote_control_word_three_reg, o_action);
        cmd[2] = pick(i_command_input_sel_3, remote_control_word_three_reg, o_action);
        signed_in[0] = apply_sign(i_input_sign_select_1, cmd[0]);
        signed_in[1] = apply_sign(i_input_sign_select_2, cmd[1]);
        signed_in[2] = apply_sign(i_input_sign_select_3, cmd[2]);
        stage_one = combine(i_combine_operator_select_1, signed_in[0], signed_in[1]);
        result_next = combine(i_combine_operator_select_2, stage_one, signed_in[2]);
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            result_reg <= 1'b0;
        end else if (i_ce) begin
            result_reg <= result_next;
        end
    end

    assign o_equation_result = result_reg;

    lee_delay_timer #(
        .WIDTH(DELAY_WIDTH)
    ) u_delay (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_level(result_reg),
        .i_on_delay(i_on_delay),
        .i_off_delay(i_off_delay),
        .o_level(o_action)
    );

    property p_word_write;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_obj_write && i_obj_index == LEE_CTRL_WORD_INDEX)
            |=> (o_remote_bits == $past(i_obj_data));
    endproperty
    a_word_write: assert property (p_word_write) else $error("word not stored");

    property p_word_hold;
        @(posedge i_clock) disable iff (i_rst)
        !(i_ce && i_obj_write && i_obj_index == LEE_CTRL_WORD_INDEX)
            |=> $stable(o_remote_bits);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word changed");

    property p_zero_path;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_input_sign_select_1 == 2'(LEE_SIGN_ZERO)
            && i_input_sign_select_2 == 2'(LEE_SIGN_ZERO)
            && i_combine_operator_select_1 == 3'(LEE_OP_OR)
            && i_combine_operator_select_2 == 3'(LEE_OP_OR)
            && i_input_sign_select_3 == 2'(LEE_SIGN_ZERO)) |=> !o_equation_result;
    endproperty
    a_zero_path: assert property (p_zero_path) else $error("forced zero not false");

    property p_one_nand;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_input_sign_select_1 == 2'(LEE_SIGN_ONE)
            && i_input_sign_select_2 == 2'(LEE_SIGN_ONE)
            && i_combine_operator_select_1 == 3'(LEE_OP_NAND)
            && i_combine_operator_select_2 == 3'(LEE_OP_NXOR)
            && i_input_sign_select_3 == 2'(LEE_SIGN_ZERO)) |=> o_equation_result;
    endproperty
    a_one_nand: assert property (p_one_nand) else $error("nand then nxor wrong");

    // Inverted first bit against plain third bit, read straight from the stored word.
    assign value_chain = ~remote_control_word_three_reg[i_command_input_sel_1[3:0]]
        ^ remote_control_word_three_reg[i_command_input_sel_3[3:0]];

    property p_value_pass;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_input_sign_select_1 == 2'(LEE_SIGN_NOT)
            && i_command_input_sel_1 <= LEE_SEL_REMOTE_MAX
            && i_input_sign_select_2 == 2'(LEE_SIGN_ONE)
            && i_combine_operator_select_1 == 3'(LEE_OP_AND)
            && i_input_sign_select_3 == 2'(LEE_SIGN_VALUE)
            && i_command_input_sel_3 <= LEE_SEL_REMOTE_MAX
            && i_combine_operator_select_2 == 3'(LEE_OP_XOR))
            |=> o_equation_result == $past(value_chain);
    endproperty
    a_value_pass: assert property (p_value_pass) else $error("sign chain wrong");

    property p_action_zero_delay;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_on_delay == '0 && result_reg && !o_action) |=> o_action;
    endproperty
    a_action_zero_delay: assert property (p_action_zero_delay) else $error("no activation");

    property p_release_zero_delay;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_off_delay == '0 && !result_reg && o_action) |=> !o_action;
    endproperty
    a_release_zero_delay: assert property (p_release_zero_delay) else $error("no release");

    property p_freeze;
        @(posedge i_clock) disable iff (i_rst)
        !i_ce |=> $stable(o_equation_result) && $stable(o_action);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_ignored_index;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_obj_write && i_obj_index != LEE_CTRL_WORD_INDEX) |=> $stable(o_remote_bits);
    endproperty
    a_ignored_index: assert property (p_ignored_index) else $error("foreign index stored");

    property p_unused_op;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && i_combine_operator_select_2 > 3'(LEE_OP_NXOR)) |=> !o_equation_result;
    endproperty
    a_unused_op: assert property (p_unused_op) else $error("unused operator not false");

    property p_action_needs_result;
        @(posedge i_clock) disable iff (i_rst)
        $rose(o_action) |-> $past(result_reg);
    endproperty
    a_action_needs_result: assert property (p_action_needs_result) else $error("action without result");

    property p_feedback_hold;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && o_action && i_command_input_sel_1 == LEE_SEL_OWN_OUTPUT
            && i_input_sign_select_1 == 2'(LEE_SIGN_VALUE)
            && i_combine_operator_select_1 == 3'(LEE_OP_OR)
            && i_combine_operator_select_2 == 3'(LEE_OP_OR)) |=> o_equation_result;
    endproperty
    a_feedback_hold: assert property (p_feedback_hold) else $error("own output not fed back");
endmodule : lee_evaluator

// file: core/lee_pkg.sv
// Package with constants and types for the logic equation evaluator.
package lee_pkg;
    localparam int LEE_CTRL_WIDTH = 16;
    localparam logic [15:0] LEE_CTRL_WORD_INDEX = 16'h21F9;
    localparam logic [15:0] LEE_CTRL_RESET = 16'h0000;
    localparam int LEE_DELAY_WIDTH = 16;
    localparam int LEE_INPUTS = 3;
    localparam int LEE_SEL_WIDTH = 5;
    localparam logic [4:0] LEE_SEL_REMOTE_MAX = 5'h0F;
    localparam logic [4:0] LEE_SEL_OWN_OUTPUT = 5'h10;

    typedef enum logic [1:0] {
        LEE_SIGN_VALUE,
        LEE_SIGN_NOT,
        LEE_SIGN_ZERO,
        LEE_SIGN_ONE
    } lee_sign_e;

    typedef enum logic [2:0] {
        LEE_OP_AND,
        LEE_OP_NAND,
        LEE_OP_OR,
        LEE_OP_NOR,
        LEE_OP_XOR,
        LEE_OP_NXOR
    } lee_op_e;
endpackage : lee_pkg

// file: verification/lee_evaluator_bench.sv
// Self-checking bench for the logic equation evaluator.
`timescale 1ns/1ps
module lee_evaluator_bench;
    import lee_pkg::*;
    logic i_clock, i_rst, i_ce, obj_write, eq_result, action;
    logic [15:0] obj_index, obj_data, on_d, off_d, remote_bits;
    logic [4:0] sel [3];
    logic [1:0] sgn [3];
    logic [2:0] op1, op2;
    int errors, n_compared, cycles;
    lee_plc_model i_plc (.i_clock(i_clock), .o_obj_write(obj_write), .o_obj_index(obj_index),
        .o_obj_data(obj_data));
    lee_evaluator i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
        .i_obj_write(obj_write), .i_obj_index(obj_index), .i_obj_data(obj_data),
        .i_command_input_sel_1(sel[0]), .i_command_input_sel_2(sel[1]),
        .i_command_input_sel_3(sel[2]), .i_input_sign_select_1(sgn[0]),
        .i_input_sign_select_2(sgn[1]), .i_input_sign_select_3(sgn[2]),
        .i_combine_operator_select_1(op1), .i_combine_operator_select_2(op2),
        .i_on_delay(on_d), .i_off_delay(off_d), .o_remote_bits(remote_bits),
        .o_equation_result(eq_result), .o_action(action));
    task automatic summarize();
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick
    task automatic drive1(input logic [1:0] s);
        @(posedge i_clock);
        sgn[0] <= s;
    endtask : drive1
    function automatic logic f_sign(input logic v, input logic [1:0] s);
        case (s)
            2'h0: return v;
            2'h1: return ~v;
            2'h2: return 1'b0;
            default: return 1'b1;
        endcase
    endfunction : f_sign
    function automatic logic f_op(input logic a, input logic b, input logic [2:0] o);
        case (o)
            3'h0: return a & b;
            3'h1: return ~(a & b);
            3'h2: return a | b;
            3'h3: return ~(a | b);
            3'h4: return a ^ b;
            default: return ~(a ^ b);
        endcase
    endfunction : f_op
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        logic e;
        i_rst = 1'b1;
        i_ce = 1'b1;
        sel = '{5'h00, 5'h01, 5'h02};
        sgn = '{2'h0, 2'h3, 2'h3};
        op1 = 3'h0;
        op2 = 3'h0;
        on_d = 16'h0000;
        off_d = 16'h0000;
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        tick(1);
        check("reset bits", remote_bits, LEE_CTRL_RESET);
        check("reset action", action, 16'h0000);
        check("reset result", eq_result, 16'h0000);
        for (int b = 0; b < 16; b++) begin
            i_plc.send(LEE_CTRL_WORD_INDEX, 16'h0001 << b);
            sel[0] <= 5'(b);
            tick(1);
            check("one-hot word", remote_bits, 16'h0001 << b);
            check("bit select", eq_result, 16'h0001);
        end
        i_plc.send(16'h21F8, 16'hFFFF);
        tick(1);
        check("wrong index", remote_bits, 16'h8000);
        @(posedge i_clock);
        i_ce <= 1'b0;
        i_plc.send(LEE_CTRL_WORD_INDEX, 16'h5A5A);
        i_ce <= 1'b1;
        tick(1);
        check("ce low", remote_bits, 16'h8000);
        @(posedge i_clock);
        sel <= '{5'h00, 5'h01, 5'h02};
        for (int s = 0; s < 4; s++)
            for (int o1 = 0; o1 < 6; o1++)
                for (int o2 = 0; o2 < 6; o2++)
                    for (int v = 0; v < 8; v++) begin
                        i_plc.send(LEE_CTRL_WORD_INDEX, {13'h0000, 3'(v)});
                        sgn[0] <= 2'(s);
                        sgn[1] <= 2'(s + 1);
                        sgn[2] <= 2'(s + 2);
                        op1 <= 3'(o1);
                        op2 <= 3'(o2);
                        tick(1);
                        e = f_op(f_op(f_sign(v[0], 2'(s)), f_sign(v[1], 2'(s + 1)), 3'(o1)),
                            f_sign(v[2], 2'(s + 2)), 3'(o2));
                        check("equation", eq_result, {15'h0000, e});
                    end
        @(posedge i_clock);
        sgn <= '{2'h2, 2'h2, 2'h2};
        op1 <= 3'h2;
        op2 <= 3'h2;
        on_d <= 16'h0003;
        off_d <= 16'h0002;
        tick(8);
        check("idle action", action, 16'h0000);
        drive1(2'h3);
        tick(2);
        drive1(2'h2);
        tick(6);
        check("on glitch", action, 16'h0000);
        drive1(2'h3);
        tick(4);
        check("on early", action, 16'h0000);
        tick(1);
        check("on delay", action, 16'h0001);
        drive1(2'h2);
        tick(3);
        check("off early", action, 16'h0001);
        tick(1);
        check("off delay", action, 16'h0000);
        @(posedge i_clock);
        sgn <= '{2'h3, 2'h3, 2'h2};
        op1 <= 3'h1;
        op2 <= 3'h5;
        tick(1);
        check("nand nxor", eq_result, 16'h0001);
        @(posedge i_clock);
        sgn <= '{2'h1, 2'h3, 2'h0};
        op1 <= 3'h0;
        op2 <= 3'h4;
        i_plc.send(LEE_CTRL_WORD_INDEX, 16'h0001);
        tick(1);
        check("not chain set", eq_result, 16'h0000);
        i_plc.send(LEE_CTRL_WORD_INDEX, 16'h0000);
        tick(1);
        check("not chain clear", eq_result, 16'h0001);
        // Own output ORed with remote bit 2 forms a latch that only reset clears.
        @(posedge i_clock);
        sel <= '{5'h10, 5'h01, 5'h02};
        sgn <= '{2'h2, 2'h0, 2'h2};
        op1 <= 3'h2;
        op2 <= 3'h2;
        on_d <= 16'h0000;
        off_d <= 16'h0000;
        i_plc.send(LEE_CTRL_WORD_INDEX, 16'h0000);
        tick(3);
        check("feedback idle", action, 16'h0000);
        @(posedge i_clock);
        sgn[0] <= 2'h0;
        i_plc.send(LEE_CTRL_WORD_INDEX, 16'h0002);
        tick(2);
        check("feedback set", action, 16'h0001);
        i_plc.send(LEE_CTRL_WORD_INDEX, 16'h0001);
        tick(2);
        check("feedback hold", action, 16'h0001);
        check("feedback result", eq_result, 16'h0001);
        @(posedge i_clock);
        i_rst <= 1'b1;
        @(posedge i_clock);
        i_rst <= 1'b0;
        tick(1);
        check("mid reset", remote_bits, LEE_CTRL_RESET);
        check("mid reset action", action, 16'h0000);
        tick(1);
        check("after reset action", action, 16'h0000);
        check("after reset result", eq_result, 16'h0000);
        @(posedge i_clock);
        sgn <= '{2'h3, 2'h3, 2'h3};
        op1 <= 3'h0;
        op2 <= 3'h6;
        tick(2);
        check("unused operator", eq_result, 16'h0000);
        @(posedge i_clock);
        sel[0] <= 5'h11;
        sgn[0] <= 2'h1;
        op2 <= 3'h0;
        tick(2);
        check("unused select", eq_result, 16'h0001);
        summarize();
    end
endmodule : lee_evaluator_bench

// file: verification/lee_plc_model.sv
// PLC model that delivers the remote control word as single object writes.
`timescale 1ns/1ps
module lee_plc_model (
    input wire logic i_clock, // System clock.
    output logic o_obj_write, // Object write strobe.
    output logic [15:0] o_obj_index, // Object index.
    output logic [15:0] o_obj_data // Control word.
);
    initial begin
        o_obj_write = 1'b0;
        o_obj_index = 16'h0000;
        o_obj_data = 16'h0000;
    end
    // One whole word per strobe; the released bus shows the inverse so stale data cannot match.
    task automatic send(input logic [15:0] index, input logic [15:0] data);
        @(posedge i_clock);
        o_obj_write <= 1'b1;
        o_obj_index <= index;
        o_obj_data <= data;
        @(posedge i_clock);
        o_obj_write <= 1'b0;
        o_obj_index <= ~index;
        o_obj_data <= ~data;
    endtask : send
endmodule : lee_plc_model
